// ===== bicb_chatter_blocker.v
// Chatter blocker for a bank of binary indication inputs
// Operation
// RL1: An input whose state changes in a test window exceed the permitted count (0..65535) is blocked or stays blocked.
// RL2: A permitted count of zero switches chatter blocking off and no input is ever blocked.
// RL3: The initial test window lasts 1..65535 seconds and opens when a signal first appears on the input.
// RL4: The maximum number of checks before final blocking is -1..32767, with -1 meaning unlimited.
// RL5: Exceeding the count starts a pause of 1..65535 minutes during which the input stays blocked.
// RL6: After the pause a subsequent window of 2..65535 seconds counts the changes again.
// RL7: A clean subsequent window re-enables the input, otherwise another pause runs unless the check limit makes blocking final.
// RL8: A blocked input carries a chatter-suspect flag and a chatter blocking event is reported.
// RL9: A blocked single-point indication on an open-circuit input is forced to the coming state.
// RL10: A blocked single-point indication on a closed-circuit input is forced to the going state.
// RL11: A blocked double-point indication is reported in the fault state; the code forces the fault only while the first input of the pair is blocked.
// RL12: One shared set of settings serves all inputs, each input having its own enable.
// RL13: Predefined protection indications are never chatter blocked.
// RL14: Every transition in either direction counts once, in a per-input counter cleared at each window start.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bicb_defs.vh"

module bicb_chatter_blocker #(
    parameter N = 8,
    parameter CYCLES_PER_SEC = `BICB_CLK_HZ
) (
    input wire clk,
    input wire nrst,
    input wire [N-1:0] binIn,
    input wire [N-1:0] chatterEn,
    input wire [N-1:0] protInd,
    input wire [N-1:0] closedCircuit,
    input wire [N-1:0] dpFirst,
    input wire [15:0] permittedChanges,
    input wire [15:0] initTestSec,
    input wire [15:0] maxChecks,
    input wire [15:0] pauseMin,
    input wire [15:0] subsTestSec,
    input wire regWrite,
    input wire regRead,
    input wire [1:0] regAddr,
    input wire [31:0] regWdata,
    output reg [31:0] regRdata,
    output reg [N-1:0] indOut,
    output reg [N-1:0] chatter_suspect_flag,
    output reg chatterBlockEvent,
    output reg irq
);

    // ==========================================
    // Register map: status (read clears), mask, live blocked state
    localparam [1:0] ADDR_STATUS = 2'h0;
    localparam [1:0] ADDR_MASK = 2'h1;
    localparam [1:0] ADDR_BLOCKED = 2'h2;

    wire secTick;
    wire minTick;

    bicb_tick_gen #(
        .CYCLES_PER_SEC(CYCLES_PER_SEC)
    ) uTick (
        .clk(clk),
        .nrst(nrst),
        .secTick(secTick),
        .minTick(minTick)
    );

    reg [2:0] state_q [0:N-1];
    reg [15:0] changeCnt_q [0:N-1];
    reg [15:0] timer_q [0:N-1];
    reg [15:0] checks_q [0:N-1];
    reg [N-1:0] prevIn_q;
    reg [N-1:0] seen_q;
    reg [N-1:0] blocked_q;
    reg [N-1:0] blockEvt;
    reg [N-1:0] status_q;
    reg [N-1:0] mask_q;

    wire [N-1:0] changed = binIn ^ prevIn_q;
    // A zero count turns the whole function off
    wire funcOn = (permittedChanges != 16'h0); // see RL2

    // Clamp settings to their documented minimum so a zero never stalls a window
    function [15:0] atLeast;
        input [15:0] val;
        input [15:0] lim;
        begin
            atLeast = (val < lim) ? lim : val;
        end
    endfunction

    // Saturating increment keeps the count from wrapping back under the limit
    function [15:0] satInc;
        input [15:0] val;
        begin
            satInc = (val == 16'hFFFF) ? val : val + 16'h1;
        end
    endfunction

    // ==========================================
    // Per-input supervision state machine
    integer i;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < N; i = i + 1) begin
                state_q[i] <= `BICB_ST_IDLE;
                changeCnt_q[i] <= 16'h0;
                timer_q[i] <= 16'h0;
                checks_q[i] <= 16'h0;
            end
            prevIn_q <= {N{1'b0}};
            seen_q <= {N{1'b0}};
            blocked_q <= {N{1'b0}};
            blockEvt <= {N{1'b0}};
        end else begin
            prevIn_q <= binIn;
            blockEvt <= {N{1'b0}};
            for (i = 0; i < N; i = i + 1) begin
                if (!funcOn || !chatterEn[i] || protInd[i]) begin
                    // Disabled or protection input: supervision released
                    state_q[i] <= `BICB_ST_IDLE; // see RL12, see RL13
                    blocked_q[i] <= 1'b0;
                    seen_q[i] <= 1'b0;
                    changeCnt_q[i] <= 16'h0;
                end else begin
                    case (state_q[i])
                        `BICB_ST_IDLE: begin
                            // Window opens on the first applied signal
                            if (binIn[i] && !seen_q[i]) begin
                                seen_q[i] <= 1'b1;
                                state_q[i] <= `BICB_ST_INIT; // see RL3
                                timer_q[i] <= atLeast(initTestSec, `BICB_MIN_INIT_SEC);
                                changeCnt_q[i] <= 16'h0; // see RL14
                                checks_q[i] <= 16'h0;
                            end
                        end
                        `BICB_ST_INIT, `BICB_ST_SUBS: begin
                            if (changed[i])
                                changeCnt_q[i] <= satInc(changeCnt_q[i]); // see RL14
                            if (changed[i] && changeCnt_q[i] >= permittedChanges) begin
                                // Count exceeded: block now rather than at window end
                                if (maxChecks != `BICB_CHECKS_INFINITE && checks_q[i] >= maxChecks) begin
                                    state_q[i] <= `BICB_ST_FINAL; // see RL4, see RL7
                                end else begin
                                    state_q[i] <= `BICB_ST_PAUSE; // see RL1, see RL5
                                    timer_q[i] <= atLeast(pauseMin, `BICB_MIN_PAUSE_MIN);
                                    checks_q[i] <= satInc(checks_q[i]);
                                end
                                if (!blocked_q[i]) begin
                                    blockEvt[i] <= 1'b1; // see RL8
                                end
                                blocked_q[i] <= 1'b1;
                            end else if (secTick) begin
                                if (timer_q[i] == 16'h1) begin
                                    // Clean window: input released
                                    state_q[i] <= `BICB_ST_FREE; // see RL7
                                    blocked_q[i] <= 1'b0;
                                end else begin
                                    timer_q[i] <= timer_q[i] - 16'h1;
                                end
                            end
                        end
                        `BICB_ST_PAUSE: begin
                            if (minTick) begin
                                if (timer_q[i] == 16'h1) begin
                                    state_q[i] <= `BICB_ST_SUBS; // see RL6
                                    timer_q[i] <= atLeast(subsTestSec, `BICB_MIN_SUBS_SEC);
                                    changeCnt_q[i] <= 16'h0; // see RL14
                                end else begin
                                    timer_q[i] <= timer_q[i] - 16'h1;
                                end
                            end
                        end
                        `BICB_ST_FREE: begin
                            // Monitoring continues with a fresh initial window
                            state_q[i] <= `BICB_ST_INIT; // see RL3
                            timer_q[i] <= atLeast(initTestSec, `BICB_MIN_INIT_SEC);
                            changeCnt_q[i] <= 16'h0;
                            checks_q[i] <= 16'h0;
                        end
                        `BICB_ST_FINAL: begin
                            blocked_q[i] <= 1'b1; // see RL7
                        end
                        default: begin
                            state_q[i] <= `BICB_ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // ==========================================
    // Indication forcing while blocked
    wire [1:0] dpFault = `BICB_DP_FAULT;
    reg [N-1:0] indNext;
    integer k;

    // Second bit of a double point whose first bit is blocked
    function pairBlocked;
        input [N-1:0] first;
        input [N-1:0] blk;
        input integer idx;
        begin
            pairBlocked = (idx > 0) ? (first[idx-1] & blk[idx-1]) : 1'b0;
        end
    endfunction

    always @* begin
        indNext = binIn;
        for (k = 0; k < N; k = k + 1) begin
            if (blocked_q[k]) begin
                if (dpFirst[k] && k + 1 < N) begin
                    // Double point pair reads as fault, both bits set
                    indNext[k] = dpFault[1]; // see RL11
                end else begin
                    indNext[k] = ~closedCircuit[k]; // see RL9, see RL10
                end
            end
            // The second bit follows its pair even when its own input is quiet
            if (pairBlocked(dpFirst, blocked_q, k))
                indNext[k] = dpFault[0]; // see RL11
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            indOut <= {N{1'b0}};
            chatter_suspect_flag <= {N{1'b0}};
            chatterBlockEvent <= 1'b0;
        end else begin
            indOut <= indNext;
            chatter_suspect_flag <= blocked_q; // see RL8
            chatterBlockEvent <= |blockEvt; // see RL8
        end
    end

    // ==========================================
    // Register port and interrupt
    wire statusRead = regRead && (regAddr == ADDR_STATUS);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= {N{1'b0}};
            mask_q <= {N{1'b0}};
            regRdata <= 32'h0;
            irq <= 1'b0;
        end else begin
            // A new event in the clearing read's cycle survives
            status_q <= (statusRead ? {N{1'b0}} : status_q) | blockEvt;
            if (regWrite && regAddr == ADDR_MASK)
                mask_q <= regWdata[N-1:0];
            regRdata <= 32'h0;
            if (regRead) begin
                case (regAddr)
                    ADDR_STATUS: regRdata[N-1:0] <= status_q;
                    ADDR_MASK: regRdata[N-1:0] <= mask_q;
                    ADDR_BLOCKED: regRdata[N-1:0] <= blocked_q;
                    default: regRdata <= 32'h0;
                endcase
            end
            irq <= |(((statusRead ? {N{1'b0}} : status_q) | blockEvt) & mask_q);
        end
    end

endmodule
`default_nettype wire

// ===== bicb_defs.vh
// Constants for the binary input chatter blocker
`ifndef BICB_DEFS_VH
`define BICB_DEFS_VH

// ==========================================
// Clock and time base
`define BICB_CLK_HZ 25000000
`define BICB_SEC_PER_MIN 60

// ==========================================
// Setting limits
`define BICB_MIN_INIT_SEC 16'h0001
`define BICB_MIN_SUBS_SEC 16'h0002
`define BICB_MIN_PAUSE_MIN 16'h0001
`define BICB_CHECKS_INFINITE 16'hFFFF

// ==========================================
// Per-input state codes
`define BICB_ST_IDLE 3'h0
`define BICB_ST_INIT 3'h1
`define BICB_ST_FREE 3'h2
`define BICB_ST_PAUSE 3'h3
`define BICB_ST_SUBS 3'h4
`define BICB_ST_FINAL 3'h5

// ==========================================
// Double-point encoding (fault state)
`define BICB_DP_FAULT 2'h3

`endif

// ===== bicb_tick_gen.v
// Seconds and minutes tick generator for the chatter blocker
`timescale 1ns/1ps
`default_nettype none
`include "bicb_defs.vh"

module bicb_tick_gen #(
    parameter CYCLES_PER_SEC = `BICB_CLK_HZ
) (
    input wire clk,
    input wire nrst,
    output reg secTick,
    output reg minTick
);

    reg [31:0] cycleCnt_q;
    reg [5:0] secCnt_q;

    // ==========================================
    // Divide the clock to one pulse a second and one a minute
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cycleCnt_q <= 32'h0;
            secCnt_q <= 6'h0;
            secTick <= 1'b0;
            minTick <= 1'b0;
        end else begin
            secTick <= 1'b0;
            minTick <= 1'b0;
            if (cycleCnt_q == CYCLES_PER_SEC - 1) begin
                cycleCnt_q <= 32'h0;
                secTick <= 1'b1;
                if (secCnt_q == `BICB_SEC_PER_MIN - 1) begin
                    secCnt_q <= 6'h0;
                    minTick <= 1'b1;
                end else begin
                    secCnt_q <= secCnt_q + 6'h1;
                end
            end else begin
                cycleCnt_q <= cycleCnt_q + 32'h1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== bicb_chatter_blocker_sva.sv
// Assertion checker for the chatter blocker ports
`timescale 1ns/1ps
`default_nettype none
module bicb_chatter_sva #(
    parameter N = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [N-1:0] binIn,
    input wire logic [N-1:0] chatterEn,
    input wire logic [N-1:0] protInd,
    input wire logic [N-1:0] closedCircuit,
    input wire logic [N-1:0] dpFirst,
    input wire logic [15:0] permittedChanges,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic [N-1:0] indOut,
    input wire logic [N-1:0] chatter_suspect_flag,
    input wire logic chatterBlockEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire [N-1:0] flg = chatter_suspect_flag;
    wire [N-1:0] sp = ~(dpFirst | {dpFirst[N-2:0], 1'b0});
    wire [N-1:0] dpf = flg & dpFirst;
    logic [N-1:0] prevFlg_q;
    // Previous flag sample, kept in clocked code so that new flags can be told apart
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevFlg_q <= '0;
        end else begin
            prevFlg_q <= flg;
        end
    end
    wire [N-1:0] newFlg = flg & ~prevFlg_q;
    // ========
    // Blocking
    a_zero_never_blocks: assert property ((permittedChanges == 16'h0000) [*3] |-> flg == '0)
        else $error("flag set while function is off");
    a_prot_exempt: assert property ((flg & protInd & $past(protInd) & $past(protInd, 2)) == '0)
        else $error("protection indication flagged");
    a_enable_gates: assert property ((flg & ~chatterEn & ~$past(chatterEn) & ~$past(chatterEn, 2)) == '0)
        else $error("disabled input flagged");
    a_event_on_block: assert property (newFlg != '0 |-> chatterBlockEvent)
        else $error("block without event");
    a_block_needs_change: assert property (newFlg != '0 |-> $past(binIn, 2) != $past(binIn, 3))
        else $error("block without input change");
    // ========
    // Forced indications and idle read data
    a_forced_coming: assert property ((flg & sp & ~closedCircuit & ~indOut) == '0)
        else $error("open-circuit input not coming");
    a_forced_going: assert property ((flg & sp & closedCircuit & indOut) == '0)
        else $error("closed-circuit input not going");
    a_dp_fault: assert property (((dpf | {dpf[N-2:0], 1'b0}) & ~indOut) == '0)
        else $error("double point not in fault");
    a_read_idle_zero: assert property (!$past(regRead) |-> regRdata == 32'h00000000)
        else $error("read data outside read cycle");
    c_block: cover property (newFlg != '0);
    c_dp_block: cover property (dpf != '0);
    c_read: cover property ($past(regRead) && regRdata != 32'h00000000);
endmodule
bind bicb_chatter_blocker bicb_chatter_sva #(.N(N)) u_sva (.clk(clk), .nrst(nrst), .binIn(binIn),
    .chatterEn(chatterEn), .protInd(protInd), .closedCircuit(closedCircuit), .dpFirst(dpFirst),
    .permittedChanges(permittedChanges), .regRead(regRead), .regRdata(regRdata), .indOut(indOut),
    .chatter_suspect_flag(chatter_suspect_flag), .chatterBlockEvent(chatterBlockEvent));
`default_nettype wire

// ===== bicb_contact_model.sv
// Field contact model driving the binary inputs
`timescale 1ns/1ps
`default_nettype none
module bicb_contact_model #(
    parameter N = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [N-1:0] kick,
    output var logic [N-1:0] level_q
);
    // ========
    // Contacts
    // One flip per edge while kicked, so each bounce is one clean change
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            level_q <= '0;
        end else begin
            level_q <= level_q ^ kick;
        end
    end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the chatter blocker
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int N = 8;
    typedef struct { int idx; int n; logic fl; logic ind; } bicb_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [N-1:0] kick = '0;
    logic [N-1:0] binIn, indOut, flag;
    logic [N-1:0] chatterEn = 8'hFB;
    logic [N-1:0] protInd = 8'h08;
    logic [N-1:0] closedCircuit = 8'h30;
    logic [N-1:0] dpFirst = 8'h40;
    logic [15:0] permittedChanges = 16'h0001;
    logic [15:0] maxChecks = 16'h0001;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [31:0] regWdata = 32'h00000000;
    logic [31:0] regRdata;
    logic blockEvt, irq;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_evt = 0;
    // Opening rise plus n changes; natural end level is 1 for even n
    bicb_row_t rows [6] = '{'{0, 3, 1, 1}, '{1, 1, 0, 0}, '{2, 3, 0, 0}, '{3, 3, 0, 0}, '{4, 2, 1, 0},
        '{6, 3, 1, 1}};

    always #20 clk = ~clk;

    // Count block event pulses as they stand
    always @(posedge clk) begin
        if (blockEvt === 1'b1) begin
            n_evt <= n_evt + 1;
        end
    end

    bicb_contact_model #(.N(N)) u_contacts (.clk(clk), .nrst(nrst), .kick(kick), .level_q(binIn));

    bicb_chatter_blocker #(.N(N), .CYCLES_PER_SEC(10)) u_dut (.clk(clk), .nrst(nrst), .binIn(binIn),
        .chatterEn(chatterEn), .protInd(protInd), .closedCircuit(closedCircuit), .dpFirst(dpFirst),
        .permittedChanges(permittedChanges), .initTestSec(16'h0001), .maxChecks(maxChecks),
        .pauseMin(16'h0001), .subsTestSec(16'h0002), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .indOut(indOut),
        .chatter_suspect_flag(flag), .chatterBlockEvent(blockEvt), .irq(irq));

    // ========
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [31:0] v);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [31:0] v);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        // Read data stand only in the cycle after the strobe
        @(posedge clk);
        v = regRdata;
    endtask

    task automatic bounce(input int idx, input int n);
        kick[idx] <= 1'b1;
        repeat (n + 1) @(posedge clk);
        kick[idx] <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ========
    // Sequence
    initial begin
        cyc(10000);
        n_mismatch++;
        conclude();
    end

    initial begin
        logic [31:0] d;
        cyc(16);
        nrst <= 1'b1;
        cyc(2);
        foreach (rows[i]) begin
            bounce(rows[i].idx, rows[i].n);
            cyc(6);
            chk(flag[rows[i].idx], rows[i].fl);
            chk(indOut[rows[i].idx], rows[i].ind);
            $display("row %0d done", i);
        end
        chk(indOut[7], 1'b1);
        chk(n_evt, 32'h00000003);
        chk(irq, 1'b0);
        wr(2'h1, 32'h000000FF);
        cyc(2);
        chk(irq, 1'b1);
        rd(2'h2, d);
        chk(d[6:0], 7'h51);
        rd(2'h0, d);
        chk(d[6:0], 7'h51);
        rd(2'h0, d);
        chk(d, 32'h00000000);
        chk(irq, 1'b0);
        wr(2'h0, 32'h000000FF);
        rd(2'h3, d);
        chk(d, 32'h00000000);
        rd(2'h0, d);
        chk(d, 32'h00000000);
        $display("register test done");
        cyc(30);
        chk(flag[0], 1'b1);
        // Steady chatter on one input so every later window fails
        repeat (400) begin
            kick[4] <= 1'b1;
            @(posedge clk);
            kick[4] <= 1'b0;
            cyc(3);
        end
        chk(flag[0], 1'b0);
        cyc(1600);
        chk(flag[4], 1'b1);
        $display("pause test done");
        nrst <= 1'b0;
        permittedChanges <= 16'h0000;
        cyc(4);
        chk(flag, 32'h00000000);
        nrst <= 1'b1;
        cyc(2);
        bounce(0, 4);
        cyc(6);
        chk(flag[0], 1'b0);
        $display("disable test done");
        conclude();
    end
endmodule
`default_nettype wire
